// >>> hdl/uef_endpoint_fifo_status.sv
// Purpose: endpoint-indexed transmit flags and receive data/count registers on avalon-mm
// Assumes: engine strobes are one-cycle pulses synchronous to core_clk
// Notes: every access takes exactly one wait cycle; side effects land at the finishing edge
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps

// Functional notes
// - full flag when set bytes reach fifo size
// - underrun flag when engine reads empty fifo
// - error flags cleared only by fifo clear
// - underrun keeps read pointer at empty
// - overrun on full write or count at 11
// - overrun keeps write pointer at full
// - nak every transmission while error flag set
// - iso: firmware changes immediate, usb at sof
// - iso underrun flag appears at next sof
// - iso overrun flag updates immediately
// - receive data loaded by engine, read-only
// - pointers advance after engine write, cpu read
// - receive registers follow selected endpoint index
// - two-entry byte-count ring per endpoint
// - ten-bit count, upper high bits zero
module uef_endpoint_fifo_status import uef_pkg::*; #(
    parameter int unsigned NUM_EP = 4,
    parameter int unsigned TX_DEPTH = 16,
    parameter int unsigned RX_DEPTH = 64
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire uef_sie_req_s sie_req,
    input wire logic sof,
    output logic [7:0] sie_tx_byte,
    output logic [NUM_EP-1:0] tx_nak
);

    typedef struct packed {
        logic wait_q;
        logic [31:0] rdata;
        logic [EP_W-1:0] ep;
        logic [NUM_EP-1:0] iso;
        logic [NUM_EP-1:0] nak;
        logic [7:0] tx_byte;
    } uef_top_s;

    uef_top_s s;
    uef_top_s next_s;
    logic [3:0] idx;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic [7:0] wbyte;
    logic [7:0] tx_pull_byte [NUM_EP];
    uef_tx_stat_s tx_stat [NUM_EP];
    logic [7:0] rx_head [NUM_EP];
    logic [BC_W-1:0] rx_count [NUM_EP];

    if (NUM_EP < 1 || NUM_EP > (1 << EP_W)) begin : g_chk
        $error("endpoint count out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus decode: an access finishes at the edge where waitrequest is low
    assign idx = avs_address[ADDR_W-1:IDX_LSB];
    assign acc = (avs_read || avs_write) && !s.wait_q;
    assign wr_acc = acc && avs_write && avs_byteenable[0];
    assign rd_acc = acc && avs_read;
    assign wbyte = avs_writedata[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // per-endpoint fifos, each strobed only when selected
    for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
        logic sel;
        logic sie_sel;
        assign sel = (s.ep == EP_W'(e));
        assign sie_sel = (sie_req.ep == EP_W'(e));

        uef_tx_fifo #(
            .DEPTH(TX_DEPTH)
        ) u_tx (
            .core_clk(core_clk),
            .rst(rst),
            .fw_push(wr_acc && sel && idx == IDX_TX_DATA),
            .fw_byte(wbyte),
            .fw_count_wr(wr_acc && sel && idx == IDX_TX_COUNT),
            .fw_clear(wr_acc && sel && idx == IDX_TX_CONTROL && wbyte[CTL_CLEAR]),
            .iso(s.iso[e]),
            .sie_pull(sie_req.tx_pull && sie_sel),
            .sie_done(sie_req.tx_done && sie_sel),
            .sof(sof),
            .pull_byte(tx_pull_byte[e]),
            .stat(tx_stat[e])
        );

        uef_rx_fifo #(
            .DEPTH(RX_DEPTH)
        ) u_rx (
            .core_clk(core_clk),
            .rst(rst),
            .sie_push(sie_req.rx_push && sie_sel),
            .sie_byte(sie_req.rx_byte),
            .sie_end(sie_req.rx_end && sie_sel),
            .sie_len(sie_req.rx_len),
            .fw_pop(rd_acc && sel && idx == IDX_RX_DATA),
            .fw_count_adv(rd_acc && sel && idx == IDX_RX_CNT_HI),
            .head_byte(rx_head[e]),
            .head_count(rx_count[e])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state: bus handshake, read capture, control writes, nak, engine byte
    always_comb begin
        next_s = s;
        // waitrequest drops for one cycle after a request is seen
        next_s.wait_q = !((avs_read || avs_write) && s.wait_q);
        if (avs_read && s.wait_q) begin
            next_s.rdata = '0;
            unique case (idx)
                IDX_EP_SELECT: next_s.rdata[EP_W-1:0] = s.ep;
                IDX_TX_CONTROL: next_s.rdata[CTL_ISO] = s.iso[s.ep];
                IDX_TX_FLAGS: begin
                    next_s.rdata[TXF_FIF_LSB+1:TXF_FIF_LSB] = tx_stat[s.ep].fif;
                    next_s.rdata[TXF_EMPTY] = tx_stat[s.ep].empty;
                    next_s.rdata[TXF_FULL] = tx_stat[s.ep].full;
                    next_s.rdata[TXF_URF] = tx_stat[s.ep].urf;
                    next_s.rdata[TXF_OVF] = tx_stat[s.ep].ovf;
                end
                IDX_RX_DATA: next_s.rdata[7:0] = rx_head[s.ep];
                IDX_RX_CNT_LO: next_s.rdata[7:0] = rx_count[s.ep][7:0];
                IDX_RX_CNT_HI: next_s.rdata[BC_W-9:0] = rx_count[s.ep][BC_W-1:8];
                default: next_s.rdata = '0;
            endcase
        end
        // flag registers ignore plain writes; only the clear bit acts on them
        if (wr_acc) begin
            unique case (idx)
                IDX_EP_SELECT: begin
                    if (int'(wbyte) < NUM_EP) begin
                        next_s.ep = wbyte[EP_W-1:0];
                    end
                end
                IDX_TX_CONTROL: next_s.iso[s.ep] = wbyte[CTL_ISO];
                default: next_s.ep = s.ep;
            endcase
        end
        for (int e = 0; e < NUM_EP; e++) begin
            next_s.nak[e] = tx_stat[e].urf || tx_stat[e].ovf;
        end
        if (sie_req.tx_pull) begin
            next_s.tx_byte = tx_pull_byte[sie_req.ep];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; waitrequest is high out of reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.wait_q <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.wait_q;
    assign sie_tx_byte = s.tx_byte;
    assign tx_nak = s.nak;

endmodule : uef_endpoint_fifo_status

// >>> hdl/uef_pkg.sv
// Purpose: shared constants, types and helpers of the endpoint fifo status block
// Assumes: 32-bit avalon word per register, register index = byte address / 4
// Notes: fifo sizes and endpoint count are parameters of the top module
package uef_pkg;

    // bus geometry
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned EP_W = 2;
    localparam int unsigned BC_W = 10;
    localparam int unsigned IDX_LSB = 2;

    // register indices; the byte address is four times the index
    localparam logic [3:0] IDX_EP_SELECT = 4'h0;
    localparam logic [3:0] IDX_TX_DATA = 4'h1;
    localparam logic [3:0] IDX_TX_COUNT = 4'h2;
    localparam logic [3:0] IDX_TX_CONTROL = 4'h3;
    localparam logic [3:0] IDX_TX_FLAGS = 4'h4;
    localparam logic [3:0] IDX_RX_DATA = 4'h5;
    localparam logic [3:0] IDX_RX_CNT_LO = 4'h6;
    localparam logic [3:0] IDX_RX_CNT_HI = 4'h7;

    // transmit flag fields
    localparam int unsigned TXF_OVF = 0;
    localparam int unsigned TXF_URF = 1;
    localparam int unsigned TXF_FULL = 2;
    localparam int unsigned TXF_EMPTY = 3;
    localparam int unsigned TXF_FIF_LSB = 6;
    localparam logic [7:0] TX_FLAGS_RESET = 8'h08;

    // transmit control fields
    localparam int unsigned CTL_ISO = 3;
    localparam int unsigned CTL_CLEAR = 7;

    // data-set indicator codes
    localparam logic [1:0] FIF_NONE = 2'h0;
    localparam logic [1:0] FIF_SET0 = 2'h1;
    localparam logic [1:0] FIF_SET1 = 2'h2;
    localparam logic [1:0] FIF_BOTH = 2'h3;

    // request from the serial interface engine
    typedef struct packed {
        logic [EP_W-1:0] ep;
        logic tx_pull;
        logic tx_done;
        logic rx_push;
        logic [7:0] rx_byte;
        logic rx_end;
        logic [BC_W-1:0] rx_len;
    } uef_sie_req_s;

    // transmit status of one endpoint
    typedef struct packed {
        logic [1:0] fif;
        logic empty;
        logic full;
        logic urf;
        logic ovf;
    } uef_tx_stat_s;

    // indicator after a byte-count write
    function automatic logic [1:0] fif_advance(input logic [1:0] fif);
        unique case (fif)
            FIF_NONE: fif_advance = FIF_SET0;
            FIF_SET0: fif_advance = FIF_BOTH;
            FIF_SET1: fif_advance = FIF_BOTH;
            FIF_BOTH: fif_advance = FIF_BOTH;
        endcase
    endfunction : fif_advance

    // indicator after a set has been consumed
    function automatic logic [1:0] fif_retreat(input logic [1:0] fif);
        unique case (fif)
            FIF_NONE: fif_retreat = FIF_NONE;
            FIF_SET0: fif_retreat = FIF_NONE;
            FIF_SET1: fif_retreat = FIF_NONE;
            FIF_BOTH: fif_retreat = FIF_SET1;
        endcase
    endfunction : fif_retreat

endpackage : uef_pkg

// >>> hdl/uef_tx_fifo.sv
// Purpose: transmit fifo of one endpoint with full, underrun and overrun flags
// Assumes: depth is a power of two; one firmware action per cycle
// Notes: usb-side indicator and underrun changes wait for sof in isochronous mode; empty and full follow usb pulls at once
`timescale 1ns/1ps
module uef_tx_fifo import uef_pkg::*; #(
    parameter int unsigned DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic fw_push,
    input wire logic [7:0] fw_byte,
    input wire logic fw_count_wr,
    input wire logic fw_clear,
    input wire logic iso,
    input wire logic sie_pull,
    input wire logic sie_done,
    input wire logic sof,
    output logic [7:0] pull_byte,
    output uef_tx_stat_s stat
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] LVL_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] LVL_ZERO = '0;

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] level;
        logic [1:0] fif;
        logic urf;
        logic ovf;
        logic urf_pend;
        logic done_pend;
    } uef_txf_s;

    uef_txf_s s;
    uef_txf_s next_s;
    logic inc;
    logic dec;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("tx fifo depth must be a power of two");
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_s = s;
        inc = 1'b0;
        dec = 1'b0;
        if (fw_clear) begin
            // clear wipes everything, but an underrun in the same cycle still lands
            next_s = '0;
            next_s.urf = sie_pull && !iso;
            next_s.urf_pend = sie_pull && iso;
        end else begin
            if (fw_push) begin
                if (s.level == LVL_FULL) begin
                    next_s.ovf = 1'b1;
                end else begin
                    inc = 1'b1;
                    next_s.mem[s.wr_ptr] = fw_byte;
                    next_s.wr_ptr = s.wr_ptr + 1'b1;
                end
            end
            if (sie_pull) begin
                if (s.level == LVL_ZERO) begin
                    // read pointer stays parked at empty
                    if (iso) begin
                        next_s.urf_pend = 1'b1;
                    end else begin
                        next_s.urf = 1'b1;
                    end
                end else begin
                    dec = 1'b1;
                    next_s.rd_ptr = s.rd_ptr + 1'b1;
                end
            end
            if (inc && !dec) begin
                next_s.level = s.level + 1'b1;
            end else if (dec && !inc) begin
                next_s.level = s.level - 1'b1;
            end
            // consumption by usb retreats the indicator, deferred in iso mode
            if (sie_done) begin
                if (iso) begin
                    next_s.done_pend = 1'b1;
                end else begin
                    next_s.fif = fif_retreat(s.fif);
                end
            end
            if (sof) begin
                if (s.urf_pend) begin
                    next_s.urf = 1'b1;
                end
                if (s.done_pend) begin
                    next_s.fif = fif_retreat(next_s.fif);
                end
                next_s.urf_pend = next_s.urf_pend && !s.urf_pend;
                next_s.done_pend = sie_done && iso;
            end
            // firmware byte-count write acts at once in every mode
            if (fw_count_wr) begin
                if (next_s.fif == FIF_BOTH) begin
                    next_s.ovf = 1'b1;
                end
                next_s.fif = fif_advance(next_s.fif);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // status and head byte
    assign pull_byte = s.mem[s.rd_ptr];
    assign stat.fif = s.fif;
    assign stat.empty = (s.level == LVL_ZERO);
    assign stat.full = (s.level == LVL_FULL);
    assign stat.urf = s.urf;
    assign stat.ovf = s.ovf;

endmodule : uef_tx_fifo

// >>> hdl/uef_rx_fifo.sv
// Purpose: receive fifo of one endpoint with a two-entry byte-count ring
// Assumes: depth is a power of two
// Notes: engine pushes into a full fifo are dropped
`timescale 1ns/1ps
module uef_rx_fifo import uef_pkg::*; #(
    parameter int unsigned DEPTH = 64
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sie_push,
    input wire logic [7:0] sie_byte,
    input wire logic sie_end,
    input wire logic [BC_W-1:0] sie_len,
    input wire logic fw_pop,
    input wire logic fw_count_adv,
    output logic [7:0] head_byte,
    output logic [BC_W-1:0] head_count
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] LVL_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] LVL_ZERO = '0;

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] level;
        logic [1:0][BC_W-1:0] ring;
        logic ring_wr;
        logic ring_rd;
    } uef_rxf_s;

    uef_rxf_s s;
    uef_rxf_s next_s;
    logic inc;
    logic dec;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("rx fifo depth must be a power of two");
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_s = s;
        inc = sie_push && (s.level != LVL_FULL);
        dec = fw_pop && (s.level != LVL_ZERO);
        if (inc) begin
            next_s.mem[s.wr_ptr] = sie_byte;
            next_s.wr_ptr = s.wr_ptr + 1'b1;
        end
        if (dec) begin
            next_s.rd_ptr = s.rd_ptr + 1'b1;
        end
        if (inc && !dec) begin
            next_s.level = s.level + 1'b1;
        end else if (dec && !inc) begin
            next_s.level = s.level - 1'b1;
        end
        // one count per finished packet, two slots used in turn
        if (sie_end) begin
            next_s.ring[s.ring_wr] = sie_len;
            next_s.ring_wr = ~s.ring_wr;
        end
        if (fw_count_adv) begin
            next_s.ring_rd = ~s.ring_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign head_byte = s.mem[s.rd_ptr];
    assign head_count = s.ring[s.ring_rd];

endmodule : uef_rx_fifo

// >>> test/uef_status_asserts.sv
// Purpose: bus reply and nak timing checks on the endpoint fifo status block
// Assumes: one clock domain, avalon access answered after one wait cycle
// Notes: nak edges are tied back to the firmware or engine event behind them
`timescale 1ns/1ps
module uef_status_asserts import uef_pkg::*; #(
    parameter int unsigned NUM_EP = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire uef_sie_req_s sie_req,
    input wire logic sof,
    input wire logic [7:0] sie_tx_byte,
    input wire logic [NUM_EP-1:0] tx_nak
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////////////
    // firmware writes that finish at this edge
    logic done;
    logic clr_now;
    logic cause_now;
    logic [2:0] clr_q;
    logic [2:0] cause_q;
    assign done = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign clr_now = done && avs_address[5:2] == IDX_TX_CONTROL && avs_writedata[CTL_CLEAR];
    assign cause_now = sie_req.tx_pull || sof
        || (done && (avs_address[5:2] == IDX_TX_DATA || avs_address[5:2] == IDX_TX_COUNT));
    // reset counts as a clear, so nak may drop just after it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clr_q <= 3'h7;
            cause_q <= 3'h0;
        end else begin
            clr_q <= {clr_q[1:0], clr_now};
            cause_q <= {cause_q[1:0], cause_now};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered after one wait cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("waitrequest dropped with no request");
    a_rdata_holds: assert property (!$fell(avs_waitrequest) |-> $stable(avs_readdata))
        else $error("read data moved outside a read answer");
    a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address[5]
        |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_upper_zero: assert property (
        avs_read && avs_waitrequest |=> avs_readdata[31:8] == 24'h0)
        else $error("read data wider than a byte");
    a_count_hi_zero: assert property (
        avs_read && avs_waitrequest && avs_address[5:2] == IDX_RX_CNT_HI
        |=> avs_readdata[31:2] == 30'h0) else $error("count high bits not zero");
    a_nak_clear_only: assert property (
        |($past(tx_nak) & ~tx_nak) |-> |clr_q) else $error("nak dropped without fifo clear");
    a_nak_rise_cause: assert property (
        |(tx_nak & ~$past(tx_nak)) |-> |cause_q) else $error("nak raised with no cause");
    c_clear: cover property (clr_now);
    c_nak: cover property (|tx_nak);
    c_count_hi: cover property (avs_read && avs_address[5:2] == IDX_RX_CNT_HI);
endmodule : uef_status_asserts

bind uef_endpoint_fifo_status uef_status_asserts #(.NUM_EP(NUM_EP)) u_chk (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sie_req(sie_req),
    .sof(sof), .sie_tx_byte(sie_tx_byte), .tx_nak(tx_nak));

// >>> test/uef_sie_model.sv
// Purpose: serial interface engine stand-in driving engine strobes and frame starts
// Assumes: each strobe lasts one core_clk cycle
// Notes: released byte and length lines show inverted data, never the last value
`timescale 1ns/1ps
module uef_sie_model import uef_pkg::*; (
    input wire logic core_clk,
    output uef_sie_req_s sie_req,
    output logic sof
);
    initial begin
        sie_req = '0;
        sof = 1'b0;
    end
    // launched and released right after rising edges
    task automatic strobe(input uef_sie_req_s r);
        uef_sie_req_s idle;
        idle = '0;
        idle.rx_byte = ~r.rx_byte;
        idle.rx_len = ~r.rx_len;
        @(posedge core_clk);
        sie_req <= r;
        @(posedge core_clk);
        sie_req <= idle;
    endtask : strobe
    task automatic pull(input logic [1:0] e);
        strobe(uef_sie_req_s'{ep: e, tx_pull: 1'b1, default: '0});
    endtask : pull
    task automatic consume(input logic [1:0] e);
        strobe(uef_sie_req_s'{ep: e, tx_done: 1'b1, default: '0});
    endtask : consume
    task automatic push(input logic [1:0] e, input logic [7:0] b);
        strobe(uef_sie_req_s'{ep: e, rx_push: 1'b1, rx_byte: b, default: '0});
    endtask : push
    task automatic fin(input logic [1:0] e, input logic [BC_W-1:0] n);
        strobe(uef_sie_req_s'{ep: e, rx_end: 1'b1, rx_len: n, default: '0});
    endtask : fin
    // frame start pulse
    task automatic frame();
        @(posedge core_clk);
        sof <= 1'b1;
        @(posedge core_clk);
        sof <= 1'b0;
    endtask : frame
endmodule : uef_sie_model

// >>> test/test_uef_endpoint_fifo_status.sv
// Purpose: self-checking bench of the endpoint fifo status block
// Assumes: the engine model drives strobes, the bench acts as firmware
// Notes: tx fifo shrunk to 4 bytes so full and overrun come quickly
`timescale 1ns/1ps
module test_uef_endpoint_fifo_status import uef_pkg::*; ;
    localparam logic [31:0] ALL = '1;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] avs_address;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    uef_sie_req_s sie_req;
    logic sof;
    logic [7:0] sie_tx_byte;
    logic [3:0] tx_nak;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    always #2.5 core_clk = ~core_clk;
    uef_endpoint_fifo_status #(.NUM_EP(4), .TX_DEPTH(4), .RX_DEPTH(8)) DUT (
        .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sie_req(sie_req),
        .sof(sof), .sie_tx_byte(sie_tx_byte), .tx_nak(tx_nak));
    uef_sie_model sie (.core_clk(core_clk), .sie_req(sie_req), .sof(sof));
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    // a hang costs a mismatch and ends the run
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        compares++;
        if ((got & m) !== (exp & m)) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got & m, exp & m);
        end
    endtask : chk
    // request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(q, exp, m);
    endtask : rd
    task automatic nak(input logic [3:0] e);
        chk({28'h0, tx_nak}, {28'h0, e}, 32'hf);
    endtask : nak
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(IDX_TX_FLAGS, {24'h0, TX_FLAGS_RESET}, ALL);
        rd(IDX_RX_DATA, 32'h0, ALL);
        rd(IDX_RX_CNT_LO, 32'h0, ALL);
        rd(IDX_RX_CNT_HI, 32'h0, ALL);
        rd(4'h9, 32'h0, ALL);
        nak(4'h0);
        $display("reset values done");
    endtask : t_reset
    task automatic t_full();
        wr(IDX_EP_SELECT, 8'h01);
        for (int i = 0; i < 4; i++) wr(IDX_TX_DATA, 8'ha0 + 8'(i));
        rd(IDX_TX_FLAGS, 32'h04, 32'h0d);
        wr(IDX_TX_COUNT, 8'h04);
        sie.pull(2'd1);
        @(negedge core_clk);
        chk({24'h0, sie_tx_byte}, 32'ha0, 32'hff);
        rd(IDX_TX_FLAGS, 32'h00, 32'h05);
        wr(IDX_TX_DATA, 8'ha4);
        rd(IDX_TX_FLAGS, 32'h04, 32'h05);
        wr(IDX_TX_DATA, 8'ha5);
        rd(IDX_TX_FLAGS, 32'h05, 32'h05);
        nak(4'h2);
        wr(IDX_TX_FLAGS, 8'h00);
        rd(IDX_TX_FLAGS, 32'h01, 32'h01);
        // the byte that overran must never reach the engine
        for (int i = 1; i < 5; i++) begin
            sie.pull(2'd1);
            @(negedge core_clk);
            chk({24'h0, sie_tx_byte}, 32'ha0 + i, 32'hff);
        end
        wr(IDX_TX_CONTROL, 8'h80);
        rd(IDX_TX_FLAGS, 32'h08, ALL);
        nak(4'h0);
        $display("full and overrun done");
    endtask : t_full
    task automatic t_count();
        wr(IDX_EP_SELECT, 8'h00);
        wr(IDX_TX_COUNT, 8'h00);
        wr(IDX_TX_COUNT, 8'h00);
        rd(IDX_TX_FLAGS, 32'hc0, 32'hc1);
        sie.consume(2'd0);
        rd(IDX_TX_FLAGS, 32'h80, 32'hc1);
        wr(IDX_TX_COUNT, 8'h00);
        rd(IDX_TX_FLAGS, 32'hc0, 32'hc1);
        wr(IDX_TX_COUNT, 8'h00);
        rd(IDX_TX_FLAGS, 32'hc1, 32'hc1);
        nak(4'h1);
        wr(IDX_TX_CONTROL, 8'h80);
        rd(IDX_TX_FLAGS, 32'h08, ALL);
        $display("count overrun done");
    endtask : t_count
    task automatic t_under();
        wr(IDX_EP_SELECT, 8'h02);
        sie.pull(2'd2);
        rd(IDX_TX_FLAGS, 32'h0a, 32'h0b);
        nak(4'h4);
        wr(IDX_TX_CONTROL, 8'h80);
        rd(IDX_TX_FLAGS, 32'h08, ALL);
        wr(IDX_TX_CONTROL, 8'h08);
        wr(IDX_TX_COUNT, 8'h00);
        rd(IDX_TX_FLAGS, 32'h40, 32'hc2);
        sie.consume(2'd2);
        sie.pull(2'd2);
        rd(IDX_TX_FLAGS, 32'h40, 32'hc2);
        nak(4'h0);
        sie.frame();
        rd(IDX_TX_FLAGS, 32'h02, 32'hc2);
        for (int i = 0; i < 3; i++) wr(IDX_TX_COUNT, 8'h00);
        rd(IDX_TX_FLAGS, 32'hc3, 32'hc3);
        wr(IDX_TX_CONTROL, 8'h80);
        rd(IDX_TX_FLAGS, 32'h08, ALL);
        wr(IDX_TX_CONTROL, 8'h00);
        $display("underrun and isochronous done");
    endtask : t_under
    task automatic t_rx();
        for (int i = 1; i < 4; i++) sie.push(2'd3, 8'h11 * 8'(i));
        sie.fin(2'd3, 10'h2a5);
        sie.push(2'd3, 8'h44);
        sie.fin(2'd3, 10'h001);
        avs_byteenable <= 4'he;
        wr(IDX_EP_SELECT, 8'h03);
        avs_byteenable <= 4'hf;
        rd(IDX_EP_SELECT, 32'h02, ALL);
        wr(IDX_EP_SELECT, 8'h03);
        rd(IDX_RX_CNT_LO, 32'ha5, ALL);
        rd(IDX_RX_CNT_HI, 32'h02, ALL);
        rd(IDX_RX_DATA, 32'h11, ALL);
        wr(IDX_RX_DATA, 8'hff);
        for (int i = 2; i < 5; i++) rd(IDX_RX_DATA, 32'h11 * i, ALL);
        rd(IDX_RX_CNT_LO, 32'h01, ALL);
        rd(IDX_RX_CNT_HI, 32'h00, ALL);
        wr(IDX_EP_SELECT, 8'h00);
        rd(IDX_RX_CNT_LO, 32'h00, ALL);
        $display("receive path done");
    endtask : t_rx
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_full();
        t_count();
        t_under();
        t_rx();
        give_verdict();
    end
endmodule : test_uef_endpoint_fifo_status
